// ==== hw/pafm_mux.sv ====
// Purpose: Alternate-function routing for ports A, B and C
// Assumes: Peripheral signals are on clk_sys; pins pass a synchroniser
// Notes: Analog functions are reported as select flags only
`timescale 1ns/10ps
`default_nettype none
module pafm_mux #(
  parameter int WIDTH = pafm_pkg::PAFM_PORT_W,
  parameter logic [7:0] BOTH_EDGE_MASK = 8'hf0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic xtal_enable,
  input wire logic [WIDTH-1:0] pa_af_en,
  input wire logic [WIDTH-1:0] pb_af_en,
  input wire logic [WIDTH-1:0] pc_af_en,
  input wire logic [WIDTH-1:0] pb_function_set_one,
  input wire logic [WIDTH-1:0] pc_function_set_one,
  input wire logic [WIDTH-1:0] pb_function_set_two,
  input wire logic [WIDTH-1:0] pc_function_set_two,
  input wire logic [WIDTH-1:0] pa_dir_in,
  input wire logic [WIDTH-1:0] pb_dir_in,
  input wire logic [WIDTH-1:0] pc_dir_in,
  input wire logic [WIDTH-1:0] pa_gpio_out,
  input wire logic [WIDTH-1:0] pb_gpio_out,
  input wire logic [WIDTH-1:0] pc_gpio_out,
  input wire logic [WIDTH-1:0] pa_pin_i,
  input wire logic [WIDTH-1:0] pb_pin_i,
  input wire logic [WIDTH-1:0] pc_pin_i,
  input wire logic [WIDTH-1:0] pa_irq_fall_sel,
  output logic [WIDTH-1:0] pa_pin_o,
  output logic [WIDTH-1:0] pa_pin_oe,
  output logic [WIDTH-1:0] pb_pin_o,
  output logic [WIDTH-1:0] pb_pin_oe,
  output logic [WIDTH-1:0] pc_pin_o,
  output logic [WIDTH-1:0] pc_pin_oe,
  output logic [WIDTH-1:0] pa_gpio_in,
  output logic [WIDTH-1:0] pb_gpio_in,
  output logic [WIDTH-1:0] pc_gpio_in,
  output logic [WIDTH-1:0] pa_irq_req,
  input wire logic timer_zero_in_or_inv_out_o,
  input wire logic timer_zero_in_or_inv_out_oe,
  output logic timer_zero_in_or_inv_out_i,
  input wire logic timer_zero_output,
  input wire logic timer_one_in_or_inv_out_o,
  input wire logic timer_one_in_or_inv_out_oe,
  output logic timer_one_in_or_inv_out_i,
  input wire logic timer_one_output,
  input wire logic serial_driver_enable,
  output logic serial_clear_to_send,
  output logic serial_receive_data,
  input wire logic serial_transmit_data,
  output logic external_clock_input,
  output logic external_clock_sel,
  output logic [WIDTH-1:0] pb_analog_sel,
  output logic [WIDTH-1:0] pc_analog_sel,
  output logic [1:0] comparator_input_sel,
  input wire logic comparator_output,
  input wire logic [WIDTH-1:0] led_sink_on,
  output logic [WIDTH-1:0] pc_led_sel,
  output logic [WIDTH-1:0] pb_function_set_two_rd,
  output logic [WIDTH-1:0] pc_function_set_two_rd
);
  import pafm_pkg::*;
  logic [WIDTH-1:0] pa_sync;
  logic [WIDTH-1:0] pb_sync;
  logic [WIDTH-1:0] pc_sync;
  logic [WIDTH-1:0] pa_act;
  logic [WIDTH-1:0] pb_sel1;
  logic [WIDTH-1:0] pc_sel1;
  logic [WIDTH-1:0] pc_sel0;
  logic [WIDTH-1:0] pa_alt_o;
  logic [WIDTH-1:0] pa_alt_oe;
  logic [WIDTH-1:0] pa_o_next;
  logic [WIDTH-1:0] pa_oe_next;
  logic [WIDTH-1:0] pc_o_next;
  logic [WIDTH-1:0] pc_oe_next;
  logic [WIDTH-1:0] pb_o_next;
  logic [WIDTH-1:0] pb_oe_next;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      pafm_pin_edge u_a (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pin_in(pa_pin_i[gi]),
        .edge_sel(pa_irq_fall_sel[gi]), .both_edges(BOTH_EDGE_MASK[gi]),
        .pin_sync(pa_sync[gi]), .edge_req(pa_irq_req[gi])
      );
      pafm_pin_edge u_b (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pin_in(pb_pin_i[gi]),
        .edge_sel(1'b0), .both_edges(1'b1),
        .pin_sync(pb_sync[gi]), .edge_req()
      );
      pafm_pin_edge u_c (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pin_in(pc_pin_i[gi]),
        .edge_sel(1'b0), .both_edges(1'b1),
        .pin_sync(pc_sync[gi]), .edge_req()
      );
    end
  endgenerate

  assign pa_act = pa_af_en & ~{{(WIDTH-2){1'b0}}, {2{xtal_enable}}};
  assign pb_sel1 = pb_af_en & pb_function_set_one;
  assign pc_sel1 = pc_af_en & pc_function_set_one;
  assign pc_sel0 = pc_af_en & ~pc_function_set_one;
  assign pb_function_set_two_rd = pb_function_set_two;
  assign pc_function_set_two_rd = pc_function_set_two;

  always_comb begin
    pa_alt_o = '0;
    pa_alt_oe = '0;
    pa_alt_o[0] = timer_zero_in_or_inv_out_o;
    pa_alt_oe[0] = timer_zero_in_or_inv_out_oe;
    pa_alt_o[1] = timer_zero_output;
    pa_alt_oe[1] = 1'b1;
    pa_alt_o[2] = serial_driver_enable;
    pa_alt_oe[2] = 1'b1;
    pa_alt_o[5] = serial_transmit_data;
    pa_alt_oe[5] = 1'b1;
    pa_alt_o[6] = timer_one_in_or_inv_out_o;
    pa_alt_oe[6] = timer_one_in_or_inv_out_oe;
    pa_alt_o[7] = timer_one_output;
    pa_alt_oe[7] = 1'b1;
  end

  assign timer_zero_in_or_inv_out_i = pa_act[0] & pa_sync[0];
  assign timer_one_in_or_inv_out_i = pa_act[6] & pa_sync[6];
  // Idle high so a disabled receiver sees a stop level
  assign serial_receive_data = pa_act[4] ? pa_sync[4] : 1'b1;
  assign serial_clear_to_send = pa_act[3] ? pa_sync[3] : 1'b1;
  assign external_clock_sel = pb_af_en[PAFM_PB_CLK_PIN] & ~pb_function_set_one[PAFM_PB_CLK_PIN];
  assign external_clock_input = external_clock_sel & pb_sync[PAFM_PB_CLK_PIN];
  assign pb_analog_sel = pb_sel1 & (PAFM_PB_ANALOG_MASK | 8'h08);
  assign pc_analog_sel = pc_sel1 & PAFM_PC_ANALOG_MASK;
  assign comparator_input_sel = pc_sel1[1:0] & PAFM_PC_COMPIN_MASK[1:0];
  assign pc_led_sel = pc_sel1 & PAFM_PC_LED_MASK;
  assign pa_gpio_in = pa_sync;
  assign pb_gpio_in = pb_sync;
  assign pc_gpio_in = pc_sync;

  always_comb begin
    pa_o_next = pa_gpio_out;
    pa_oe_next = ~pa_dir_in;
    pb_o_next = pb_gpio_out;
    pb_oe_next = ~pb_dir_in;
    pc_o_next = pc_gpio_out;
    pc_oe_next = ~pc_dir_in;
    for (int i = 0; i < WIDTH; i++) begin
      if (pa_act[i]) begin
        pa_o_next[i] = pa_alt_o[i];
        pa_oe_next[i] = pa_alt_oe[i];
      end
      if (xtal_enable && i < 2) begin
        pa_oe_next[i] = 1'b0;
      end
      if (pb_af_en[i]) begin
        pb_oe_next[i] = 1'b0;
      end
      if (pc_sel1[i]) begin
        // LED sink: drive low only while the sink is on
        pc_o_next[i] = 1'b0;
        pc_oe_next[i] = led_sink_on[i];
      end else if (pc_sel0[i]) begin
        pc_o_next[i] = (i == PAFM_PC_COMP_PIN) ? comparator_output : 1'b0;
        pc_oe_next[i] = (i == PAFM_PC_COMP_PIN);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pa_pin_o <= '0;
      pa_pin_oe <= '0;
      pb_pin_o <= '0;
      pb_pin_oe <= '0;
      pc_pin_o <= '0;
      pc_pin_oe <= '0;
    end else begin
      pa_pin_o <= pa_o_next;
      pa_pin_oe <= pa_oe_next;
      pb_pin_o <= pb_o_next;
      pb_pin_oe <= pb_oe_next;
      pc_pin_o <= pc_o_next;
      pc_pin_oe <= pc_oe_next;
    end
  end

  property p_xtal;
    @(posedge clk_sys) disable iff (sys_rst) xtal_enable |=> (pa_pin_oe[1:0] == 2'b00);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pins driven");
  property p_timer0;
    @(posedge clk_sys) disable iff (sys_rst)
      (pa_af_en[1] && !xtal_enable) |=> (pa_pin_o[1] == $past(timer_zero_output));
  endproperty
  a_timer0: assert property (p_timer0) else $error("timer output not routed");
  property p_txd;
    @(posedge clk_sys) disable iff (sys_rst)
      pa_af_en[5] |=> (pa_pin_oe[5] && pa_pin_o[5] == $past(serial_transmit_data));
  endproperty
  a_txd: assert property (p_txd) else $error("transmit not routed");
  property p_gpio_dir;
    @(posedge clk_sys) disable iff (sys_rst)
      (!pa_af_en[7]) |=> (pa_pin_oe[7] == !$past(pa_dir_in[7]));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("direction not honoured");
  property p_clk_sel;
    @(posedge clk_sys) disable iff (sys_rst)
      (pb_af_en[3] && !pb_function_set_one[3]) |->
        (external_clock_sel && external_clock_input == pb_gpio_in[3]);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");
  property p_gate;
    @(posedge clk_sys) disable iff (sys_rst) (pc_af_en == 8'h00) |-> (pc_led_sel == 8'h00);
  endproperty
  a_gate: assert property (p_gate) else $error("led without enable");
  property p_comp;
    @(posedge clk_sys) disable iff (sys_rst)
      (pc_af_en[3] && !pc_function_set_one[3]) |=>
        (pc_pin_oe[3] && pc_pin_o[3] == $past(comparator_output));
  endproperty
  a_comp: assert property (p_comp) else $error("comparator not routed");
  property p_pb67;
    @(posedge clk_sys) disable iff (sys_rst) pb_analog_sel[7:6] == 2'b00;
  endproperty
  a_pb67: assert property (p_pb67) else $error("pins 6,7 selected");
  property p_set2;
    @(posedge clk_sys) disable iff (sys_rst)
      $changed(pc_function_set_two) && $stable(pc_function_set_one) && $stable(pc_af_en)
        |-> $stable(pc_led_sel);
  endproperty
  a_set2: assert property (p_set2) else $error("set two changed routing");
  c_led: cover property (@(posedge clk_sys) pc_led_sel != 8'h00);
  c_clk: cover property (@(posedge clk_sys) external_clock_sel);
  c_irq: cover property (@(posedge clk_sys) pa_irq_req != 8'h00);
endmodule // pafm_mux

`default_nettype wire

// ==== hw/pafm_pin_edge.sv ====
// Purpose: Pin synchroniser and edge detector for one pin
// Assumes: Pin is asynchronous to clk_sys
// Notes: Change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pafm_pin_edge (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pin_in,
  input wire logic edge_sel,
  input wire logic both_edges,
  output logic pin_sync,
  output logic edge_req
);
  import pafm_pkg::*;
  logic [PAFM_SYNC_STAGES-1:0] sync_reg;
  logic stable_reg;
  logic rise;
  logic fall;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[PAFM_SYNC_STAGES-2:0], pin_in};
    end
  end

  // Only stages two and three are looked at
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stable_reg <= 1'b0;
    end else if (sync_reg[1] == sync_reg[2]) begin
      stable_reg <= sync_reg[2];
    end
  end

  assign rise = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !stable_reg;
  assign fall = (sync_reg[1] == sync_reg[2]) && !sync_reg[2] && stable_reg;
  assign pin_sync = stable_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      edge_req <= 1'b0;
    end else if (both_edges) begin
      edge_req <= rise | fall;
    end else begin
      edge_req <= edge_sel ? fall : rise;
    end
  end

  property p_edge_cause;
    @(posedge clk_sys) disable iff (sys_rst) edge_req |-> $past(rise | fall);
  endproperty
  a_edge_cause: assert property (p_edge_cause) else $error("edge request without edge");
endmodule // pafm_pin_edge

`default_nettype wire

// ==== hw/pafm_pkg.sv ====
// Purpose: Constants and types for the port alternate-function multiplexer
// Assumes: Three 8-bit ports, one system clock, synchronous reset
// Notes: Functional notes below
`default_nettype none
package pafm_pkg;
  localparam int PAFM_PORT_W = 8;
  localparam logic [7:0] PAFM_AF_RST = 8'h00;
  localparam logic [7:0] PAFM_DIR_RST = 8'hff;
  localparam logic [7:0] PAFM_SET_RST = 8'h00;
  localparam int PAFM_PB_CLK_PIN = 3;
  localparam int PAFM_PC_COMP_PIN = 3;
  localparam logic [7:0] PAFM_PB_ANALOG_MASK = 8'h37;
  localparam logic [7:0] PAFM_PC_ANALOG_MASK = 8'h07;
  localparam logic [7:0] PAFM_PC_LED_MASK = 8'hff;
  localparam logic [7:0] PAFM_PC_COMPIN_MASK = 8'h03;
  localparam int PAFM_SYNC_STAGES = 3;
endpackage : pafm_pkg

`default_nettype wire

// ==== verif/pafm_periph_model.sv ====
// Purpose: On-chip peripherals that sit behind the alternate-function mux
// Assumes: Peripherals run on clk_sys; no fault injection is needed
// Notes: Outputs follow a step counter so a stale or wrong route shows
`timescale 1ns/10ps
`default_nettype none
module pafm_periph_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic timer_zero_in_or_inv_out_o,
  output logic timer_zero_in_or_inv_out_oe,
  output logic timer_zero_output,
  output logic timer_one_in_or_inv_out_o,
  output logic timer_one_in_or_inv_out_oe,
  output logic timer_one_output,
  output logic serial_driver_enable,
  output logic serial_transmit_data,
  output logic comparator_output
);
  logic [3:0] step_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      step_reg <= 4'h0;
    end else begin
      step_reg <= step_reg + 4'h1;
    end
  end
  // Timers swap between input and output mode to exercise both enables
  assign timer_zero_in_or_inv_out_o = step_reg[0];
  assign timer_zero_in_or_inv_out_oe = step_reg[3];
  assign timer_zero_output = step_reg[1];
  assign timer_one_in_or_inv_out_o = step_reg[2];
  assign timer_one_in_or_inv_out_oe = ~step_reg[3];
  assign timer_one_output = step_reg[3];
  assign serial_driver_enable = ~step_reg[0];
  assign serial_transmit_data = ~step_reg[1];
  assign comparator_output = step_reg[1] ^ step_reg[2];
endmodule // pafm_periph_model
`default_nettype wire

// ==== verif/tb_pafm_mux.sv ====
// Purpose: Self-checking bench for the alternate-function mux
// Assumes: Pin inputs settle through the synchroniser within six cycles
// Notes: Port outputs compared one cycle after the peripheral value
`timescale 1ns/10ps
`default_nettype none
module tb_pafm_mux;
  import pafm_pkg::*;
  logic clk_sys, sys_rst, xtal_enable;
  logic [7:0] pa_af_en, pb_af_en, pc_af_en, pb_function_set_one, pc_function_set_one;
  logic [7:0] pb_function_set_two, pc_function_set_two, pa_dir_in, pb_dir_in, pc_dir_in;
  logic [7:0] pa_gpio_out, pb_gpio_out, pc_gpio_out, pa_pin_i, pb_pin_i, pc_pin_i;
  logic [7:0] pa_irq_fall_sel, led_sink_on, pa_pin_o, pa_pin_oe, pb_pin_o, pb_pin_oe;
  logic [7:0] pc_pin_o, pc_pin_oe, pa_gpio_in, pb_gpio_in, pc_gpio_in, pa_irq_req;
  logic [7:0] pb_analog_sel, pc_analog_sel, pc_led_sel;
  logic [7:0] pb_function_set_two_rd, pc_function_set_two_rd;
  logic [1:0] comparator_input_sel;
  logic timer_zero_in_or_inv_out_o, timer_zero_in_or_inv_out_oe, timer_zero_in_or_inv_out_i;
  logic timer_zero_output, timer_one_in_or_inv_out_o, timer_one_in_or_inv_out_oe;
  logic timer_one_in_or_inv_out_i, timer_one_output, serial_driver_enable;
  logic serial_clear_to_send, serial_receive_data, serial_transmit_data;
  logic external_clock_input, external_clock_sel, comparator_output;
  int n_mismatch = 0;
  int comparisons = 0;
  int pulses;
  logic [7:0] exp_o, exp_oe, acc;

  pafm_mux #(.BOTH_EDGE_MASK(8'hf0)) pafm_mux_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .xtal_enable(xtal_enable),
    .pa_af_en(pa_af_en), .pb_af_en(pb_af_en), .pc_af_en(pc_af_en),
    .pb_function_set_one(pb_function_set_one), .pc_function_set_one(pc_function_set_one),
    .pb_function_set_two(pb_function_set_two), .pc_function_set_two(pc_function_set_two),
    .pa_dir_in(pa_dir_in), .pb_dir_in(pb_dir_in), .pc_dir_in(pc_dir_in),
    .pa_gpio_out(pa_gpio_out), .pb_gpio_out(pb_gpio_out), .pc_gpio_out(pc_gpio_out),
    .pa_pin_i(pa_pin_i), .pb_pin_i(pb_pin_i), .pc_pin_i(pc_pin_i),
    .pa_irq_fall_sel(pa_irq_fall_sel), .pa_pin_o(pa_pin_o), .pa_pin_oe(pa_pin_oe),
    .pb_pin_o(pb_pin_o), .pb_pin_oe(pb_pin_oe), .pc_pin_o(pc_pin_o), .pc_pin_oe(pc_pin_oe),
    .pa_gpio_in(pa_gpio_in), .pb_gpio_in(pb_gpio_in), .pc_gpio_in(pc_gpio_in),
    .pa_irq_req(pa_irq_req),
    .timer_zero_in_or_inv_out_o(timer_zero_in_or_inv_out_o),
    .timer_zero_in_or_inv_out_oe(timer_zero_in_or_inv_out_oe),
    .timer_zero_in_or_inv_out_i(timer_zero_in_or_inv_out_i),
    .timer_zero_output(timer_zero_output),
    .timer_one_in_or_inv_out_o(timer_one_in_or_inv_out_o),
    .timer_one_in_or_inv_out_oe(timer_one_in_or_inv_out_oe),
    .timer_one_in_or_inv_out_i(timer_one_in_or_inv_out_i),
    .timer_one_output(timer_one_output), .serial_driver_enable(serial_driver_enable),
    .serial_clear_to_send(serial_clear_to_send), .serial_receive_data(serial_receive_data),
    .serial_transmit_data(serial_transmit_data), .external_clock_input(external_clock_input),
    .external_clock_sel(external_clock_sel), .pb_analog_sel(pb_analog_sel),
    .pc_analog_sel(pc_analog_sel), .comparator_input_sel(comparator_input_sel),
    .comparator_output(comparator_output), .led_sink_on(led_sink_on), .pc_led_sel(pc_led_sel),
    .pb_function_set_two_rd(pb_function_set_two_rd),
    .pc_function_set_two_rd(pc_function_set_two_rd)
  );
  pafm_periph_model pafm_periph_model_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .timer_zero_in_or_inv_out_o(timer_zero_in_or_inv_out_o),
    .timer_zero_in_or_inv_out_oe(timer_zero_in_or_inv_out_oe),
    .timer_zero_output(timer_zero_output),
    .timer_one_in_or_inv_out_o(timer_one_in_or_inv_out_o),
    .timer_one_in_or_inv_out_oe(timer_one_in_or_inv_out_oe),
    .timer_one_output(timer_one_output), .serial_driver_enable(serial_driver_enable),
    .serial_transmit_data(serial_transmit_data), .comparator_output(comparator_output)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic complete_run;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Port A routing seen one cycle after the peripheral value
  task automatic chk_pa(input logic xt);
    repeat (8) begin
      @(negedge clk_sys);
      exp_o = {timer_one_output, timer_one_in_or_inv_out_o, serial_transmit_data, 2'b00,
               serial_driver_enable, timer_zero_output, timer_zero_in_or_inv_out_o};
      exp_oe = {1'b1, timer_one_in_or_inv_out_oe, 4'h9, xt ? 2'b00 : {1'b1,
                timer_zero_in_or_inv_out_oe}};
      @(negedge clk_sys);
      chk(pa_pin_o & (xt ? 8'he4 : 8'he7), exp_o & (xt ? 8'he4 : 8'he7));
      chk(pa_pin_oe, exp_oe);
      // Odd spacing so counter bit 0 toggles between samples
      @(negedge clk_sys);
    end
  endtask

  // Edge pulses collected over a window
  task automatic irq_win(input logic [7:0] lvl, input logic [7:0] exp);
    @(posedge clk_sys);
    pa_pin_i <= lvl;
    acc = 8'h00;
    pulses = 0;
    repeat (10) begin
      cyc(1);
      if (pa_irq_req !== 8'h00) pulses++;
      acc = acc | pa_irq_req;
    end
    chk(acc, exp);
    chk(8'(pulses), 8'h01);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    xtal_enable = 1'b0;
    {pa_af_en, pb_af_en, pc_af_en, pb_function_set_one, pc_function_set_one} = '0;
    {pb_function_set_two, pc_function_set_two, pa_gpio_out, pb_gpio_out} = '0;
    {pc_gpio_out, pa_pin_i, pb_pin_i, pc_pin_i, pa_irq_fall_sel, led_sink_on} = '0;
    {pa_dir_in, pb_dir_in, pc_dir_in} = {3{PAFM_DIR_RST}};
    cyc(3);
    sys_rst <= 1'b0;
    cyc(1);
    chk(pa_pin_oe | pb_pin_oe | pc_pin_oe, 8'h00);
    // GPIO direction only while alternate is off
    pa_dir_in <= 8'h0f;
    pa_gpio_out <= 8'ha5;
    pb_dir_in <= 8'h00;
    pb_gpio_out <= 8'h3c;
    pc_dir_in <= 8'hf0;
    pc_gpio_out <= 8'h69;
    cyc(3);
    chk(pa_pin_o, 8'ha5);
    chk(pa_pin_oe, 8'hf0);
    chk(pb_pin_oe, 8'hff);
    chk(pb_pin_o, 8'h3c);
    chk(pc_pin_o, 8'h69);
    chk(pc_pin_oe, 8'h0f);
    $display("test gpio done");
    // Port A single function per pin, direction ignored
    pa_af_en <= 8'hff;
    pa_dir_in <= 8'hff;
    cyc(3);
    chk_pa(1'b0);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      pa_pin_i <= k[0] ? 8'h49 : 8'h10;
      cyc(6);
      chk(pa_gpio_in, k[0] ? 8'h49 : 8'h10);
      chk({6'h0, serial_receive_data, serial_clear_to_send}, k[0] ? 8'h01 : 8'h02);
      chk({6'h0, timer_one_in_or_inv_out_i, timer_zero_in_or_inv_out_i},
          k[0] ? 8'h03 : 8'h00);
    end
    // Crystal overrides pins 0 and 1
    xtal_enable <= 1'b1;
    cyc(3);
    chk_pa(1'b1);
    xtal_enable <= 1'b0;
    $display("test port a done");
    // Port B: set one chooses, set two ignored, enable needed
    pb_af_en <= 8'hff;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      pb_function_set_one <= k[0] ? 8'h3f : 8'h37;
      pb_function_set_two <= k[1] ? 8'hff : 8'h00;
      pb_pin_i <= k[0] ? 8'h00 : 8'h08;
      cyc(6);
      chk(pb_function_set_two_rd, k[1] ? 8'hff : 8'h00);
      chk(pb_analog_sel, k[0] ? 8'h3f : 8'h37);
      chk({6'h0, external_clock_sel, external_clock_input}, k[0] ? 8'h00 : 8'h03);
      chk(pb_pin_oe, 8'h00);
      chk(pb_gpio_in, k[0] ? 8'h00 : 8'h08);
    end
    // Enable off drops every port B function
    pb_af_en <= 8'h00;
    cyc(2);
    chk(pb_pin_oe, 8'hff);
    chk(pb_analog_sel, 8'h00);
    chk({7'h0, external_clock_sel}, 8'h00);
    $display("test port b done");
    // Port C: comparator output at zero, LED and analog at one
    pc_af_en <= 8'hff;
    pc_pin_i <= 8'h96;
    cyc(3);
    pc_function_set_two <= 8'hff;
    repeat (4) begin
      @(negedge clk_sys);
      exp_o = {4'h0, comparator_output, 3'h0};
      @(negedge clk_sys);
      chk(pc_pin_o & 8'h08, exp_o);
      chk(pc_pin_oe, 8'h08);
    end
    chk(pc_function_set_two_rd, 8'hff);
    chk(pc_gpio_in, 8'h96);
    chk(pc_led_sel, 8'h00);
    @(posedge clk_sys);
    pc_function_set_one <= 8'hff;
    led_sink_on <= 8'h5a;
    cyc(3);
    chk(pc_led_sel, 8'hff);
    chk(pc_analog_sel, 8'h07);
    chk({6'h0, comparator_input_sel}, 8'h03);
    chk(pc_pin_o, 8'h00);
    chk(pc_pin_oe, 8'h5a);
    pc_af_en <= 8'h0f;
    cyc(3);
    chk(pc_led_sel, 8'h0f);
    chk(pc_pin_oe, 8'h0a);
    $display("test port c done");
    // Selectable edge on pins 0 to 3, both edges above
    pa_af_en <= 8'h00;
    pa_irq_fall_sel <= 8'h03;
    pa_pin_i <= 8'h00;
    cyc(8);
    irq_win(8'hff, 8'hfc);
    irq_win(8'h00, 8'hf3);
    $display("test irq done");
    complete_run();
  end
endmodule // tb_pafm_mux
`default_nettype wire
